// >>> core/uart_holding_irq.sv
// holding registers, fifos, start-bit check and interrupt enable of one uart channel
// assumes a host port with one-cycle strobes and read data one cycle later
`timescale 1ns/10ps
module uart_holding_irq #(
  parameter int DEPTH    = 16,   // fifo entries
  parameter int BAUD_DIV = uart_hold_pkg::BAUD_DIV_DEFAULT  // clk per 16x tick
) (
  input  wire logic       clk,        // 250 MHz
  input  wire logic       nrst,       // async, active low
  input  wire logic [2:0] addr,       // register address
  input  wire logic [7:0] wrData,     // write data
  input  wire logic       wrStb,      // write strobe
  input  wire logic       rdStb,      // read strobe
  output logic      [7:0] rdData,     // read data, cycle after strobe
  input  wire logic       rxPin,      // serial input
  output logic            txPin,      // serial output
  input  wire logic       ctsPin,     // clear-to-send level (high = asserted)
  input  wire logic       rtsLevel,   // rts level from flow logic
  input  wire logic       xoffSeen,   // one-cycle pulse: xoff char received
  input  wire logic [3:0] modemDelta, // modem change pulses
  output logic            irqOutA,    // channel interrupt
  output logic            sleepMode   // sleep enable
);
  localparam int AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || BAUD_DIV < 1)
    $error("uart_holding_irq: DEPTH power of two >=2, BAUD_DIV >= 1");
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum {TX_IDLE, TX_SHIFT} tx_state_t;

  logic [7:0] ienReg, fifoCtlReg, lineCtlReg, rdDataReg;
  logic [3:0] modemStaReg;
  logic [7:0] txMem [DEPTH];
  logic [8:0] rxMem [DEPTH];  // bit 8: framing error (bad stop bit) with the char
  logic [AW:0] txWp, txRp, rxWp, rxRp;
  logic       overrunReg, breakReg, frameErrReg, ctsIrqReg, rtsIrqReg, xoffIrqReg;
  logic       txIrqClrReg, ctsPrev, rtsPrev, tick, txPinReg, irqReg;
  logic [2:0] rxSync, ctsSync;
  logic [15:0] divCnt;
  rx_state_t  rxState;
  tx_state_t  txState;
  logic [3:0] rxTick, txTick, rxBit, txBit;
  logic [7:0] rxShift;
  logic [9:0] txShift;

  wire dlab     = lineCtlReg[uart_hold_pkg::LCR_DLAB];
  wire fifoOn   = fifoCtlReg[uart_hold_pkg::FCR_EN];
  wire selData  = (addr == uart_hold_pkg::ADDR_DATA) && !dlab;
  wire selIen   = (addr == uart_hold_pkg::ADDR_IEN) && !dlab;
  wire hostWrTx = wrStb && selData;
  wire hostRdRx = rdStb && selData;
  wire rdIid    = rdStb && (addr == uart_hold_pkg::ADDR_FIFO);
  wire [AW:0] capacity = fifoOn ? (AW+1)'(DEPTH) : (AW+1)'(1);
  wire [AW:0] txCount = txWp - txRp;
  wire [AW:0] rxCount = rxWp - rxRp;
  wire txEmpty = (txCount == '0);
  wire rxEmpty = (rxCount == '0);
  wire txFull  = (txCount >= capacity);
  wire rxFull  = (rxCount >= capacity);
  wire [AW:0] trigLevel = fifoOn ? (AW+1)'(1) << fifoCtlReg[7:6] : (AW+1)'(1);
  wire rxAtTrig = (rxCount >= trigLevel);
  wire txLoad   = (txState == TX_IDLE) && !txEmpty && tick;
  wire rxDone   = (rxState == RX_STOP) && tick && (rxTick == uart_hold_pkg::OVERSAMPLE_LAST);
  wire stopBad  = !rxSync[2];
  wire rxFall   = rxSync[2] && !rxSync[1] && (rxSync[1] == rxSync[0]);
  wire rxPush   = rxDone && !rxFull;  // errored chars are kept, flagged in bit 8
  wire txPush   = hostWrTx && !txFull;
  wire rxPop    = hostRdRx && !rxEmpty;
  wire ctsRise  = ctsSync[2] && !ctsPrev && (ctsSync[1] == ctsSync[2]);
  wire rtsRise  = rtsLevel && !rtsPrev;
  wire errInFifo;

  wire lineErr = overrunReg | frameErrReg | breakReg;
  wire [7:0] lineSta = {errInFifo,
                        txEmpty && (txState == TX_IDLE),
                        txEmpty,
                        breakReg, frameErrReg, 1'b0, overrunReg,
                        !rxEmpty};
  logic [DEPTH-1:0] errBits;
  for (genvar g = 0; g < DEPTH; g++)
  begin : g_err
    wire [AW:0] idx = rxRp + (AW+1)'(g);
    assign errBits[g] = (AW+1)'(g) < rxCount && rxMem[idx[AW-1:0]][8];
  end
  assign errInFifo = |errBits;

  wire srcLine  = ienReg[uart_hold_pkg::IEN_LINE] && lineErr;
  wire srcRx    = ienReg[uart_hold_pkg::IEN_RX] && !rxEmpty && rxAtTrig;
  wire srcTx    = ienReg[uart_hold_pkg::IEN_TX] && txEmpty && !txIrqClrReg;
  wire srcModem = ienReg[uart_hold_pkg::IEN_MODEM] && (modemStaReg != '0);
  wire srcXoff  = ienReg[uart_hold_pkg::IEN_XOFF] && xoffIrqReg;
  wire srcFlow  = (ienReg[uart_hold_pkg::IEN_CTS] && ctsIrqReg) ||
                  (ienReg[uart_hold_pkg::IEN_RTS] && rtsIrqReg);
  wire anyIrq = srcLine | srcRx | srcTx | srcModem | srcXoff | srcFlow;
  wire [7:0] iidCode = srcLine ? uart_hold_pkg::IID_LINE :
                       srcRx   ? uart_hold_pkg::IID_RX   :
                       srcTx   ? uart_hold_pkg::IID_TX   :
                       srcModem ? uart_hold_pkg::IID_MODEM :
                       srcXoff ? uart_hold_pkg::IID_XOFF :
                       srcFlow ? uart_hold_pkg::IID_FLOW : uart_hold_pkg::IID_NONE;
  wire [7:0] iidRead = iidCode | (fifoOn ? uart_hold_pkg::IID_FIFOS : 8'h00);

  wire [7:0] rdMux =
    selData ? rxMem[rxRp[AW-1:0]][7:0] :
    selIen  ? ienReg :
    (addr == uart_hold_pkg::ADDR_FIFO) ? iidRead :
    (addr == uart_hold_pkg::ADDR_LCTL) ? lineCtlReg :
    (addr == uart_hold_pkg::ADDR_LSTA) ? lineSta :
    (addr == uart_hold_pkg::ADDR_MSTA) ? {4'h0, modemStaReg} : 8'h00;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      ienReg     <= uart_hold_pkg::IEN_RESET;
      fifoCtlReg <= uart_hold_pkg::FIFO_RESET;
      lineCtlReg <= uart_hold_pkg::LCTL_RESET;
      rdDataReg  <= 8'h00;
    end
    else
    begin
      if (wrStb && selIen)
        ienReg <= wrData;
      if (wrStb && addr == uart_hold_pkg::ADDR_FIFO)
        fifoCtlReg <= {wrData[7:3], 2'b00, wrData[0]};
      if (wrStb && addr == uart_hold_pkg::ADDR_LCTL)
        lineCtlReg <= wrData;
      if (rdStb)
        rdDataReg <= rdMux;
    end

  // ---- sticky events: set beats clear
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      modemStaReg <= 4'h0;
      ctsIrqReg   <= 1'b0;
      rtsIrqReg   <= 1'b0;
      xoffIrqReg  <= 1'b0;
      txIrqClrReg <= 1'b0;
      ctsPrev     <= 1'b0;
      rtsPrev     <= 1'b0;
    end
    else
    begin
      ctsPrev <= ctsSync[2];
      rtsPrev <= rtsLevel;
      modemStaReg <= modemDelta |
        ((rdStb && addr == uart_hold_pkg::ADDR_MSTA) ? 4'h0 : modemStaReg);
      ctsIrqReg  <= ctsRise | (ctsIrqReg & !rdIid);
      rtsIrqReg  <= rtsRise | (rtsIrqReg & !rdIid);
      xoffIrqReg <= xoffSeen | (xoffIrqReg & !rdIid);
      // a new empty event (last char leaves) re-arms the tx interrupt
      if (txLoad && txCount == (AW+1)'(1))
        txIrqClrReg <= 1'b0;
      else if ((rdIid && iidCode == uart_hold_pkg::IID_TX) || txPush)
        txIrqClrReg <= 1'b1;
    end

  // ---- fifos; capacity 1 when fifos are off
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      txWp <= '0;
      txRp <= '0;
      rxWp <= '0;
      rxRp <= '0;
    end
    else
    begin
      if (wrStb && addr == uart_hold_pkg::ADDR_FIFO && wrData[uart_hold_pkg::FCR_TXCLR])
        txWp <= txRp;
      else if (txPush)
        txWp <= txWp + (AW+1)'(1);
      if (txLoad)
        txRp <= txRp + (AW+1)'(1);
      if (wrStb && addr == uart_hold_pkg::ADDR_FIFO && wrData[uart_hold_pkg::FCR_RXCLR])
        rxRp <= rxWp;
      else if (rxPop)
        rxRp <= rxRp + (AW+1)'(1);
      if (rxPush)
        rxWp <= rxWp + (AW+1)'(1);
    end

  always_ff @(posedge clk)
    if (txPush)
      txMem[txWp[AW-1:0]] <= wrData;
  always_ff @(posedge clk)
    if (rxPush)
      rxMem[rxWp[AW-1:0]] <= {stopBad, rxShift};

  // ---- 16x tick divider; sleep stops it only while nothing is pending
  wire sleeping = ienReg[uart_hold_pkg::IEN_SLEEP] && txEmpty &&
                  txState == TX_IDLE && rxState == RX_IDLE;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      divCnt <= 16'h0000;
      tick   <= 1'b0;
      rxSync <= 3'b111;
      ctsSync <= 3'b000;
    end
    else
    begin
      rxSync  <= {rxSync[1:0], rxPin};
      ctsSync <= {ctsSync[1:0], ctsPin};
      tick    <= 1'b0;
      if (sleeping)
        divCnt <= 16'h0000;
      else if (divCnt == 16'(BAUD_DIV - 1))
      begin
        divCnt <= 16'h0000;
        tick   <= 1'b1;
      end
      else
        divCnt <= divCnt + 16'h0001;
    end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      rxState     <= RX_IDLE;
      rxTick      <= 4'h0;
      rxBit       <= 4'h0;
      rxShift     <= 8'h00;
      overrunReg  <= 1'b0;
      frameErrReg <= 1'b0;
      breakReg    <= 1'b0;
    end
    else
    begin
      if (rdStb && addr == uart_hold_pkg::ADDR_LSTA)
      begin
        overrunReg  <= 1'b0;
        frameErrReg <= 1'b0;
        breakReg    <= 1'b0;
      end
      case (rxState)
        RX_IDLE:
          if (rxFall)
          begin
            rxState <= RX_START;
            rxTick  <= 4'h0;
          end
        RX_START:
          if (tick)
          begin
            rxTick <= rxTick + 4'h1;
            if (rxTick == uart_hold_pkg::MID_SAMPLE)
            begin
              if (rxSync[2])
                rxState <= RX_IDLE;
              else
              begin
                rxState <= RX_DATA;
                rxTick  <= 4'h0;
                rxBit   <= 4'h0;
              end
            end
          end
        RX_DATA:
          if (tick)
          begin
            rxTick <= rxTick + 4'h1;
            if (rxTick == uart_hold_pkg::OVERSAMPLE_LAST)
            begin
              rxShift <= {rxSync[2], rxShift[7:1]};
              rxBit   <= rxBit + 4'h1;
              if (rxBit == 4'h7)
                rxState <= RX_STOP;
            end
          end
        RX_STOP:
          if (tick)
          begin
            rxTick <= rxTick + 4'h1;
            if (rxDone)
            begin
              rxState <= RX_IDLE;
              if (stopBad && rxShift == 8'h00)
                breakReg <= 1'b1;
              else if (stopBad)
                frameErrReg <= 1'b1;
              else if (rxFull)
                overrunReg <= 1'b1;
            end
          end
        default:
          rxState <= RX_IDLE;
      endcase
    end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      txState  <= TX_IDLE;
      txShift  <= 10'h3FF;
      txTick   <= 4'h0;
      txBit    <= 4'h0;
      txPinReg <= 1'b1;
      irqReg   <= 1'b0;
    end
    else
    begin
      irqReg <= anyIrq;
      case (txState)
        TX_IDLE:
          if (txLoad)
          begin
            txShift <= {1'b1, txMem[txRp[AW-1:0]], 1'b0};
            txState <= TX_SHIFT;
            txTick  <= 4'h0;
            txBit   <= 4'h0;
          end
        TX_SHIFT:
          if (tick)
          begin
            txTick <= txTick + 4'h1;
            if (txTick == 4'h0)
              txPinReg <= txShift[0];
            if (txTick == uart_hold_pkg::OVERSAMPLE_LAST)
            begin
              txShift <= {1'b1, txShift[9:1]};
              txBit   <= txBit + 4'h1;
              if (txBit == 4'h9)
                txState <= TX_IDLE;
            end
          end
        default:
          txState <= TX_IDLE;
      endcase
    end

  assign rdData    = rdDataReg;
  assign txPin     = txPinReg;
  assign irqOutA   = irqReg;
  assign sleepMode = ienReg[uart_hold_pkg::IEN_SLEEP];

  property p_txpush;
    @(posedge clk) disable iff (!nrst) txPush |=> !txEmpty || txState == TX_SHIFT;
  endproperty
  a_txpush: assert property (p_txpush) else $error("tx write lost");
  property p_thre;
    @(posedge clk) disable iff (!nrst) txLoad && txCount == (AW+1)'(1) && !txPush |=> lineSta[5];
  endproperty
  a_thre: assert property (p_thre) else $error("holding empty flag wrong");
  property p_rxpop;
    @(posedge clk) disable iff (!nrst) rxPop && !rxPush |=> rxCount == $past(rxCount) - (AW+1)'(1);
  endproperty
  a_rxpop: assert property (p_rxpop) else $error("rx read did not pop");
  property p_falsestart;
    @(posedge clk) disable iff (!nrst)
      rxState == RX_START && tick && rxTick == uart_hold_pkg::MID_SAMPLE && rxSync[2]
      |=> rxState == RX_IDLE;
  endproperty
  a_falsestart: assert property (p_falsestart) else $error("false start accepted");
  property p_start;
    @(posedge clk) disable iff (!nrst) rxState == RX_IDLE && rxFall |=> rxState == RX_START;
  endproperty
  a_start: assert property (p_start) else $error("start edge missed");
  property p_quiet;
    @(posedge clk) disable iff (!nrst) ienReg == 8'h00 |=> !irqOutA;
  endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt with sources off");
  property p_txclr;
    @(posedge clk) disable iff (!nrst) txPush |=> !srcTx;
  endproperty
  a_txclr: assert property (p_txclr) else $error("tx interrupt not cleared");
  property p_dr;
    @(posedge clk) disable iff (!nrst) rxPush |=> lineSta[0];
  endproperty
  a_dr: assert property (p_dr) else $error("data ready not set");
  property p_irqpin;
    @(posedge clk) disable iff (!nrst) srcRx |=> irqOutA;
  endproperty
  a_irqpin: assert property (p_irqpin) else $error("rx interrupt not on pin");
endmodule

// >>> core/uart_hold_pkg.sv
// register map, field positions, reset values and timing for one uart channel
// assumes a byte-wide host port with 3-bit register addresses
package uart_hold_pkg;
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IEN  = 3'h1;
  localparam logic [2:0] ADDR_FIFO = 3'h2;
  localparam logic [2:0] ADDR_LCTL = 3'h3;
  localparam logic [2:0] ADDR_LSTA = 3'h5;
  localparam logic [2:0] ADDR_MSTA = 3'h6;
  localparam logic [7:0] IEN_RESET  = 8'h00;
  localparam logic [7:0] FIFO_RESET = 8'h00;
  localparam logic [7:0] LCTL_RESET = 8'h00;
  localparam int IEN_RX = 0, IEN_TX = 1, IEN_LINE = 2, IEN_MODEM = 3;
  localparam int IEN_SLEEP = 4, IEN_XOFF = 5, IEN_RTS = 6, IEN_CTS = 7;
  localparam int FCR_EN = 0, FCR_RXCLR = 1, FCR_TXCLR = 2, LCR_DLAB = 7;
  localparam logic [7:0] IID_NONE  = 8'h01;
  localparam logic [7:0] IID_LINE  = 8'h06;
  localparam logic [7:0] IID_RX    = 8'h04;
  localparam logic [7:0] IID_TX    = 8'h02;
  localparam logic [7:0] IID_MODEM = 8'h00;
  localparam logic [7:0] IID_XOFF  = 8'h10;
  localparam logic [7:0] IID_FLOW  = 8'h20;
  localparam logic [7:0] IID_FIFOS = 8'hC0;
  localparam logic [3:0] MID_SAMPLE = 4'h7;   // 7.5 ticks: sample after 8th tick
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam int BAUD_DIV_DEFAULT = 16;
endpackage

// >>> test/serial_peer.sv
// serial line partner of the uart channel: sends 8N1 frames, captures frames sent to it
// assumes one bench clock and a bit time given in clock cycles
`timescale 1ns/10ps
module serial_peer #(
  parameter int BIT = 16  // clocks per serial bit
) (
  input  wire logic clk,    // bench clock
  input  wire logic txLine, // serial out of the block
  output logic      rxLine  // serial in of the block, idles high
);
  logic [7:0] got[$];
  logic [7:0] sh;

  initial rxLine = 1'b1;

  // lsb first, stop level chosen so a framing fault can be made
  task automatic send(input logic [7:0] b, input logic stopLvl);
    @(posedge clk);
    rxLine <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      rxLine <= b[i];
      repeat (BIT) @(posedge clk);
    end
    rxLine <= stopLvl;
    repeat (BIT) @(posedge clk);
    rxLine <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask

  // short low pulse, ends well before the start-bit centre
  task automatic glitch(input int n);
    @(posedge clk);
    rxLine <= 1'b0;
    repeat (n) @(posedge clk);
    rxLine <= 1'b1;
    repeat (2 * BIT) @(posedge clk);
  endtask

  initial
  begin
    forever
    begin
      @(negedge txLine);
      repeat (BIT / 2) @(posedge clk);
      if (txLine === 1'b0)
      begin
        for (int i = 0; i < 8; i++)
        begin
          repeat (BIT) @(posedge clk);
          sh[i] = txLine;
        end
        got.push_back(sh);
        repeat (BIT) @(posedge clk);
      end
    end
  end
endmodule

// >>> test/uart_holding_and_irq_enable_tb.sv
// self-checking bench for the uart holding registers and interrupt enable
// assumes uart_hold_pkg, uart_holding_irq and serial_peer are compiled first
`timescale 1ns/10ps
module uart_holding_and_irq_enable_tb;
  localparam int BIT   = 16;     // BAUD_DIV of 1 in simulation
  localparam int LIMIT = 60000;  // run needs well under 10000 cycles
  logic       clk, nrst, wrStb, rdStb, rxPin, txPin, ctsPin;
  logic       rtsLevel, xoffSeen, irqOutA, sleepMode;
  logic [2:0] addr;
  logic [7:0] wrData, rdData, v;
  logic [3:0] modemDelta;
  int         failures, checks, cycles;

  uart_holding_irq #(.DEPTH(16), .BAUD_DIV(1)) dut (
    .clk(clk), .nrst(nrst), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .rxPin(rxPin), .txPin(txPin), .ctsPin(ctsPin), .rtsLevel(rtsLevel),
    .xoffSeen(xoffSeen), .modemDelta(modemDelta), .irqOutA(irqOutA), .sleepMode(sleepMode));

  serial_peer #(.BIT(BIT)) peer (.clk(clk), .txLine(txPin), .rxLine(rxPin));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge clk);
    wrStb  <= 1'b0;
  endtask

  // data stand from the cycle after the strobe until the next read strobe
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    @(posedge clk);
    v = rdData;
  endtask

  task automatic wait_irq(input logic exp, input int n);
    for (int i = 0; i < n && irqOutA !== exp; i++) @(posedge clk);
    chk("irqOutA", {7'h00, exp}, {7'h00, irqOutA});
  endtask

  task automatic wait_tx(input int n);
    for (int i = 0; i < 4000 && peer.got.size() < n; i++) @(posedge clk);
  endtask

  task automatic pulse(input logic x, input logic [3:0] m);
    @(posedge clk);
    xoffSeen   <= x;
    modemDelta <= m;
    @(posedge clk);
    xoffSeen   <= 1'b0;
    modemDelta <= 4'h0;
  endtask

  task automatic t_reset();
    chk("irqOutA", 8'h00, {7'h00, irqOutA});
    rd(uart_hold_pkg::ADDR_IEN);
    chk("enable mask", 8'h00, v);
    rd(uart_hold_pkg::ADDR_LSTA);
    chk("line status", 8'h60, v);
    rd(uart_hold_pkg::ADDR_FIFO);
    chk("identify", 8'h01, v);
  endtask

  task automatic t_tx();
    wr(uart_hold_pkg::ADDR_FIFO, 8'h01);
    peer.got.delete();
    wr(uart_hold_pkg::ADDR_DATA, 8'hA5);
    wr(uart_hold_pkg::ADDR_DATA, 8'h5A);
    wr(uart_hold_pkg::ADDR_DATA, 8'hC3);
    rd(uart_hold_pkg::ADDR_LSTA);
    chk("tx empty bits", 8'h00, v & 8'h60);
    wait_tx(3);
    chk("tx byte 0", 8'hA5, peer.got[0]);
    chk("tx byte 1", 8'h5A, peer.got[1]);
    chk("tx byte 2", 8'hC3, peer.got[2]);
    repeat (2 * BIT) @(posedge clk);
    rd(uart_hold_pkg::ADDR_LSTA);
    chk("line status", 8'h60, v);
  endtask

  task automatic t_rx();
    peer.send(8'h3C, 1'b1);
    peer.send(8'h96, 1'b1);
    rd(uart_hold_pkg::ADDR_LSTA);
    chk("data ready", 8'h01, v & 8'h01);
    rd(uart_hold_pkg::ADDR_DATA);
    chk("rx byte 0", 8'h3C, v);
    rd(uart_hold_pkg::ADDR_DATA);
    chk("rx byte 1", 8'h96, v);
    rd(uart_hold_pkg::ADDR_LSTA);
    chk("data ready", 8'h00, v & 8'h01);
    // low for half the centre time: must be dropped, next frame still taken
    peer.glitch(4);
    repeat (12 * BIT) @(posedge clk);
    rd(uart_hold_pkg::ADDR_LSTA);
    chk("false start", 8'h00, v & 8'h01);
    peer.send(8'h81, 1'b1);
    rd(uart_hold_pkg::ADDR_DATA);
    chk("rx after glitch", 8'h81, v);
  endtask

  task automatic t_trigger();
    wr(uart_hold_pkg::ADDR_FIFO, 8'h41);
    wr(uart_hold_pkg::ADDR_IEN, 8'h01);
    peer.send(8'h11, 1'b1);
    wait_irq(1'b0, 1);
    peer.send(8'h22, 1'b1);
    wait_irq(1'b1, 20);
    rd(uart_hold_pkg::ADDR_FIFO);
    chk("identify", 8'hC4, v);
    rd(uart_hold_pkg::ADDR_DATA);
    chk("rx byte", 8'h11, v);
    wait_irq(1'b0, 4);
    rd(uart_hold_pkg::ADDR_FIFO);
    chk("identify", 8'hC1, v);
    rd(uart_hold_pkg::ADDR_DATA);
    wr(uart_hold_pkg::ADDR_IEN, 8'h04);
    peer.send(8'h55, 1'b0);
    wait_irq(1'b1, 20);
    rd(uart_hold_pkg::ADDR_LSTA);
    chk("framing", 8'h89, v & 8'h89);
    wait_irq(1'b0, 4);
    rd(uart_hold_pkg::ADDR_DATA);
    wr(uart_hold_pkg::ADDR_IEN, 8'h00);
  endtask

  task automatic t_polled();
    ctsPin   <= 1'b1;
    rtsLevel <= 1'b1;
    pulse(1'b1, 4'h1);
    peer.send(8'h77, 1'b1);
    wait_irq(1'b0, 1);
    rd(uart_hold_pkg::ADDR_LSTA);
    chk("polled ready", 8'h01, v & 8'h01);
    rd(uart_hold_pkg::ADDR_FIFO);
    rd(uart_hold_pkg::ADDR_MSTA);
    rd(uart_hold_pkg::ADDR_DATA);
    chk("rx byte", 8'h77, v);
  endtask

  task automatic t_events();
    logic [7:0] mask[4] = '{8'h80, 8'h40, 8'h20, 8'h08};
    logic [7:0] id[3]   = '{8'hE0, 8'hE0, 8'hD0};
    for (int k = 0; k < 4; k++)
    begin
      wr(uart_hold_pkg::ADDR_IEN, mask[k]);
      if (k == 0) ctsPin <= 1'b0;
      if (k == 1) rtsLevel <= 1'b0;
      repeat (8) @(posedge clk);
      if (k == 0) ctsPin <= 1'b1;
      if (k == 1) rtsLevel <= 1'b1;
      if (k > 1) pulse(k == 2, {k == 3, 3'h0});
      wait_irq(1'b1, 20);
      rd(k < 3 ? uart_hold_pkg::ADDR_FIFO : uart_hold_pkg::ADDR_MSTA);
      if (k < 3) chk("identify", id[k], v);
      else chk("modem status", 8'h08, v & 8'h08);
      wait_irq(1'b0, 4);
    end
    wr(uart_hold_pkg::ADDR_IEN, 8'h02);
    wait_irq(1'b1, 8);
    rd(uart_hold_pkg::ADDR_FIFO);
    chk("identify", 8'hC2, v);
    wait_irq(1'b0, 4);
    peer.got.delete();
    wr(uart_hold_pkg::ADDR_DATA, 8'h3A);
    wait_irq(1'b1, 4 * BIT);
    rd(uart_hold_pkg::ADDR_LSTA);
    chk("tx empty bits", 8'h20, v & 8'h60);
    wr(uart_hold_pkg::ADDR_DATA, 8'h5C);
    wait_irq(1'b0, 4);
    wait_tx(2);
    chk("tx byte", 8'h3A, peer.got[0]);
    chk("tx byte", 8'h5C, peer.got[1]);
    wr(uart_hold_pkg::ADDR_IEN, 8'h00);
  endtask

  task automatic t_sleep_single();
    wr(uart_hold_pkg::ADDR_IEN, 8'h10);
    repeat (3) @(posedge clk);
    chk("sleepMode", 8'h01, {7'h00, sleepMode});
    wr(uart_hold_pkg::ADDR_IEN, 8'h00);
    repeat (3) @(posedge clk);
    chk("sleepMode", 8'h00, {7'h00, sleepMode});
    // latch access on: enable mask hidden and write dropped
    wr(uart_hold_pkg::ADDR_LCTL, 8'h80);
    wr(uart_hold_pkg::ADDR_IEN, 8'h10);
    rd(uart_hold_pkg::ADDR_IEN);
    chk("hidden mask", 8'h00, v);
    wr(uart_hold_pkg::ADDR_LCTL, 8'h00);
    rd(uart_hold_pkg::ADDR_IEN);
    chk("enable mask", 8'h00, v);
    chk("sleepMode", 8'h00, {7'h00, sleepMode});
    wr(uart_hold_pkg::ADDR_FIFO, 8'h00);
    peer.send(8'hA1, 1'b1);
    peer.send(8'hB2, 1'b1);
    rd(uart_hold_pkg::ADDR_LSTA);
    chk("overrun", 8'h03, v & 8'h03);
    rd(uart_hold_pkg::ADDR_DATA);
    chk("rx byte", 8'hA1, v);
    rd(uart_hold_pkg::ADDR_LSTA);
    chk("data ready", 8'h00, v & 8'h01);
    rd(uart_hold_pkg::ADDR_FIFO);
    chk("identify", 8'h01, v);
  endtask

  initial
  begin
    nrst = 1'b0;
    addr = 3'h0;
    wrData = 8'h00;
    wrStb = 1'b0;
    rdStb = 1'b0;
    ctsPin = 1'b0;
    rtsLevel = 1'b0;
    xoffSeen = 1'b0;
    modemDelta = 4'h0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_trigger();
    t_polled();
    t_events();
    t_sleep_single();
    close_out();
  end
endmodule
